// >>> core/mss_regs.svh
`ifndef MSS_REGS_SVH
`define MSS_REGS_SVH

// command selectors for the configuration command port
`define MSS_SEL_TX_BYTE      4'h0
`define MSS_SEL_RX_FAULT     4'h1
`define MSS_SEL_GOOD_FRAME   4'h2
`define MSS_SEL_ACK_TIMEOUT  4'h3
`define MSS_SEL_DELIV_FAIL   4'h4
`define MSS_SEL_ACKED_UNI    4'h5
`define MSS_SEL_LAST_RSSI    4'h6
`define MSS_SEL_UNI_HOP      4'h7
`define MSS_SEL_BC_HOP       4'h8
`define MSS_SEL_OPTIONS      4'h9

// number of tallies and the first one that saturates
`define MSS_NUM_TALLY        6
`define MSS_FIRST_SAT        1

// reset values and the tally maximum
`define MSS_TALLY_RST        16'h0000
`define MSS_TALLY_MAX        16'hFFFF
`define MSS_RSSI_RST         8'h00
`define MSS_UNI_HOP_RST      16'h00CF
`define MSS_BC_HOP_RST       16'h01BE
`define MSS_OPT_RST          3'h0

// node messaging option field bits
`define MSS_OPT_COORD        0
`define MSS_OPT_NOROUTE      1
`define MSS_OPT_POLL         2

// poll interval: time in ms and clock rate in kHz
`define MSS_POLL_MS          100
`define MSS_CLK_KHZ          100000

`endif

// >>> core/mss_pkg.sv
`default_nettype none
package mss_pkg;
  typedef logic [3:0]  mss_sel_t;
  typedef logic [15:0] mss_word_t;
  typedef logic [2:0]  mss_opt_t;
endpackage
`default_nettype wire

// >>> core/mss_tally.sv
`default_nettype none
`include "mss_regs.svh"
module mss_tally #(
  parameter int WIDTH    = 16,
  parameter bit SATURATE = 1'b1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             event_hit,
  output var  logic [WIDTH-1:0] count
);
  localparam logic [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};

  generate
    if (WIDTH < 1) begin : g_bad
      $error("mss_tally: WIDTH must be at least 1");
    end
  endgenerate

  // a load wins over a coinciding event; the event is dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
    end else if (load) begin
      count <= load_val;
    end else if (event_hit) begin
      if (SATURATE && count == CNT_MAX) begin
        count <= count;
      end else begin
        count <= count + 1'b1; // wraps to zero when not saturating
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/mss_stats.sv
// Function
// - count one per physical-layer byte sent in the transmit byte tally
// - transmit byte tally wraps from its maximum back to zero
// - software may load any 16-bit value into each tally
// - read-only last packet signal strength, magnitude of negative dBm
// - receive fault tally counts packets with integrity errors
// - good frame tally counts good frames with valid MAC header
// - ack timeout tally counts MAC acknowledgement timeouts on unicasts
// - delivery fail tally counts transmissions that exhausted all retries
// - acked unicast tally counts unicasts that request acknowledgement
// - all tallies except the transmit byte tally saturate at maximum
// - read-only unicast hop timeout, default value, recomputed on change
// - read-only broadcast hop timeout, default value, recomputed on change
// - coordinator bit holds point-to-multipoint unicasts until polled
// - no-route bit stops broadcast propagation, mesh relaying and repeating
// - poller bit sends periodic message requests to the coordinator
// - a routing node repeats received broadcasts
`default_nettype none
`include "mss_regs.svh"
module mss_stats #(
  parameter int POLL_CYCLES = `MSS_POLL_MS * `MSS_CLK_KHZ
) (
  input  wire logic                MCLK,
  input  wire logic                RST_N,
  input  wire logic                TX_BYTE,
  input  wire logic                RX_FAULT,
  input  wire logic                RX_GOOD,
  input  wire logic                ACK_TIMEOUT,
  input  wire logic                RETRY_EXHAUSTED,
  input  wire logic                ACKED_UNICAST,
  input  wire logic                RSSI_VALID,
  input  wire logic [7:0]          RSSI_VAL,
  input  wire logic                MAC_PARAM_CHG,
  input  wire mss_pkg::mss_word_t  UNI_HOP_IN,
  input  wire mss_pkg::mss_word_t  BC_HOP_IN,
  input  wire logic                RX_BCAST,
  input  wire logic                RELAY_REQ,
  input  wire logic                P2MP_UNICAST,
  input  wire logic                POLL_SEEN,
  input  wire logic                CMD_WR,
  input  wire logic                CMD_RD,
  input  wire mss_pkg::mss_sel_t   CMD_SEL,
  input  wire mss_pkg::mss_word_t  CMD_WDATA,
  output var  mss_pkg::mss_word_t  CMD_RDATA,
  output var  logic                CMD_RVALID,
  output var  logic                CMD_ERR,
  output var  logic                COORD_EN,
  output var  logic                ROUTE_DIS,
  output var  logic                POLL_EN,
  output var  logic                BCAST_FWD,
  output var  logic                RELAY_OK,
  output var  logic                P2MP_HOLD,
  output var  logic                P2MP_SEND,
  output var  logic                POLL_REQ
);

  localparam int NT = `MSS_NUM_TALLY;

  generate
    if (POLL_CYCLES < 2) begin : g_bad_poll
      $error("mss_stats: POLL_CYCLES must be at least 2");
    end
  endgenerate

  // true when a selector addresses tally number idx
  function automatic logic tally_hit(input mss_pkg::mss_sel_t sel,
                                     input int                idx);
    tally_hit = (sel == mss_pkg::mss_sel_t'(idx));
  endfunction

  // true when an option value is one that the node can serve
  function automatic logic opt_legal(input mss_pkg::mss_opt_t v);
    opt_legal = !(v[`MSS_OPT_COORD] && v[`MSS_OPT_POLL]);
  endfunction

  // true for selectors that accept a write
  function automatic logic sel_writable(input mss_pkg::mss_sel_t sel);
    sel_writable = (sel <= `MSS_SEL_ACKED_UNI) || (sel == `MSS_SEL_OPTIONS);
  endfunction

  // true for selectors that exist at all
  function automatic logic sel_mapped(input mss_pkg::mss_sel_t sel);
    sel_mapped = (sel <= `MSS_SEL_OPTIONS);
  endfunction

  mss_pkg::mss_word_t tally_cnt [NT];
  logic [NT-1:0]      tally_evt;
  logic [NT-1:0]      tally_ld;
  logic [7:0]         last_rssi_r;
  mss_pkg::mss_word_t uni_hop_r;
  mss_pkg::mss_word_t bc_hop_r;
  mss_pkg::mss_opt_t  opt_r;
  logic               wr_ok;
  logic [31:0]        poll_cnt_r;
  logic [31:0]        poll_cnt_nxt;

  // event sources are on MCLK already, so they go straight in
  assign tally_evt[0] = TX_BYTE;
  assign tally_evt[1] = RX_FAULT;
  assign tally_evt[2] = RX_GOOD;
  assign tally_evt[3] = ACK_TIMEOUT;
  assign tally_evt[4] = RETRY_EXHAUSTED;
  assign tally_evt[5] = ACKED_UNICAST;

  // a write is taken only to a writable selector; an option value with
  // both coordinator and poller set is refused and flagged instead
  always_comb begin
    wr_ok = CMD_WR && sel_writable(CMD_SEL);
    if (CMD_SEL == `MSS_SEL_OPTIONS &&
        !opt_legal(mss_pkg::mss_opt_t'(CMD_WDATA[2:0]))) begin
      wr_ok = 1'b0;
    end
  end

  // software load strobes, one per tally
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      tally_ld[i] = wr_ok && tally_hit(CMD_SEL, i);
    end
  end

  // the byte tally wraps, the rest saturate
  generate
    for (genvar g = 0; g < NT; g++) begin : g_tally
      mss_tally #(
        .WIDTH    (16),
        .SATURATE (g >= `MSS_FIRST_SAT)
      ) u_tally (
        .clk       (MCLK),
        .rst_n     (RST_N),
        .load      (tally_ld[g]),
        .load_val  (CMD_WDATA),
        .event_hit (tally_evt[g]),
        .count     (tally_cnt[g])
      );
    end
  endgenerate

  // signal strength of the last packet; software cannot write it
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      last_rssi_r <= `MSS_RSSI_RST;
    end else if (RSSI_VALID) begin
      last_rssi_r <= RSSI_VAL;
    end
  end

  // hop timeouts are recomputed by the MAC; we latch its result when a
  // parameter change is announced
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      uni_hop_r <= `MSS_UNI_HOP_RST;
      bc_hop_r  <= `MSS_BC_HOP_RST;
    end else if (MAC_PARAM_CHG) begin
      uni_hop_r <= UNI_HOP_IN;
      bc_hop_r  <= BC_HOP_IN;
    end
  end

  // node messaging option field
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      opt_r <= `MSS_OPT_RST;
    end else if (wr_ok && CMD_SEL == `MSS_SEL_OPTIONS) begin
      opt_r <= mss_pkg::mss_opt_t'(CMD_WDATA[2:0]);
    end
  end

  // option bits out, registered so every output leaves a flop
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      COORD_EN  <= 1'b0;
      ROUTE_DIS <= 1'b0;
      POLL_EN   <= 1'b0;
    end else begin
      COORD_EN  <= opt_r[`MSS_OPT_COORD];
      ROUTE_DIS <= opt_r[`MSS_OPT_NOROUTE];
      POLL_EN   <= opt_r[`MSS_OPT_POLL];
    end
  end

  // broadcast repeat and mesh relay decisions, one cycle after the request
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      BCAST_FWD <= 1'b0;
      RELAY_OK  <= 1'b0;
    end else begin
      BCAST_FWD <= RX_BCAST && !opt_r[`MSS_OPT_NOROUTE];
      RELAY_OK  <= RELAY_REQ && !opt_r[`MSS_OPT_NOROUTE];
    end
  end

  // point-to-multipoint unicasts: a coordinator holds them until a poll
  // arrives; without the coordinator bit they go out at once
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      P2MP_HOLD <= 1'b0;
      P2MP_SEND <= 1'b0;
    end else begin
      P2MP_SEND <= 1'b0;
      if (!opt_r[`MSS_OPT_COORD]) begin
        P2MP_HOLD <= 1'b0;
        P2MP_SEND <= P2MP_UNICAST || P2MP_HOLD;
      end else if (P2MP_HOLD && POLL_SEEN) begin
        P2MP_HOLD <= P2MP_UNICAST; // a new arrival starts a fresh hold
        P2MP_SEND <= 1'b1;
      end else if (P2MP_UNICAST) begin
        P2MP_HOLD <= 1'b1;
      end
    end
  end

  // poll interval timer; it idles at zero while polling is off so the
  // first poll comes one full interval after the bit is set
  always_comb begin
    poll_cnt_nxt = poll_cnt_r;
    if (!opt_r[`MSS_OPT_POLL]) begin
      poll_cnt_nxt = '0;
    end else if (poll_cnt_r == 32'(POLL_CYCLES - 1)) begin
      poll_cnt_nxt = '0;
    end else begin
      poll_cnt_nxt = poll_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      poll_cnt_r <= '0;
    end else begin
      poll_cnt_r <= poll_cnt_nxt;
    end
  end

  // one-cycle poll request at the end of each interval
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      POLL_REQ <= 1'b0;
    end else begin
      POLL_REQ <= opt_r[`MSS_OPT_POLL] &&
                  poll_cnt_r == 32'(POLL_CYCLES - 1);
    end
  end

  // read path: data and valid one cycle after the request; a read shows
  // the value held before any write in the same cycle
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      CMD_RDATA  <= 16'h0000;
      CMD_RVALID <= 1'b0;
    end else begin
      CMD_RVALID <= CMD_RD && sel_mapped(CMD_SEL);
      if (CMD_RD) begin
        unique case (CMD_SEL)
          `MSS_SEL_TX_BYTE:     CMD_RDATA <= tally_cnt[0];
          `MSS_SEL_RX_FAULT:    CMD_RDATA <= tally_cnt[1];
          `MSS_SEL_GOOD_FRAME:  CMD_RDATA <= tally_cnt[2];
          `MSS_SEL_ACK_TIMEOUT: CMD_RDATA <= tally_cnt[3];
          `MSS_SEL_DELIV_FAIL:  CMD_RDATA <= tally_cnt[4];
          `MSS_SEL_ACKED_UNI:   CMD_RDATA <= tally_cnt[5];
          `MSS_SEL_LAST_RSSI:   CMD_RDATA <= {8'h00, last_rssi_r};
          `MSS_SEL_UNI_HOP:     CMD_RDATA <= uni_hop_r;
          `MSS_SEL_BC_HOP:      CMD_RDATA <= bc_hop_r;
          `MSS_SEL_OPTIONS:     CMD_RDATA <= {13'h0000, opt_r};
          default:              CMD_RDATA <= 16'h0000; // unmapped
        endcase
      end
    end
  end

  // error pulse: unmapped read, write to a read-only or unmapped
  // selector, or an illegal option value
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      CMD_ERR <= 1'b0;
    end else begin
      CMD_ERR <= (CMD_RD && !sel_mapped(CMD_SEL)) ||
                 (CMD_WR && !wr_ok);
    end
  end

endmodule
`default_nettype wire

// >>> tb/mss_stats_monitor.sv
`default_nettype none
module mss_chk #(
  parameter int POLL_CYCLES = 8
) (
  input wire logic               MCLK,
  input wire logic               RST_N,
  input wire logic               RX_BCAST,
  input wire logic               RELAY_REQ,
  input wire logic               P2MP_UNICAST,
  input wire logic               POLL_SEEN,
  input wire logic               CMD_WR,
  input wire logic               CMD_RD,
  input wire mss_pkg::mss_sel_t  CMD_SEL,
  input wire mss_pkg::mss_word_t CMD_WDATA,
  input wire logic               CMD_RVALID,
  input wire logic               CMD_ERR,
  input wire logic               COORD_EN,
  input wire logic               ROUTE_DIS,
  input wire logic               POLL_EN,
  input wire logic               BCAST_FWD,
  input wire logic               RELAY_OK,
  input wire logic               P2MP_HOLD,
  input wire logic               P2MP_SEND,
  input wire logic               POLL_REQ
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap_r;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  // cycles since the last poll; restarts while polling is off
  always_ff @(posedge MCLK) begin
    if (!RST_N || POLL_REQ || !POLL_EN) begin
      gap_r <= 0;
    end else begin
      gap_r <= gap_r + 1;
    end
  end
  rd_answer_a: assert property (
    CMD_RD && CMD_SEL <= 4'h9 |=> CMD_RVALID)
    else $error("read not answered");
  ro_write_err_a: assert property (
    CMD_WR && CMD_SEL inside {4'h6, 4'h7, 4'h8} |=> CMD_ERR)
    else $error("read-only write not refused");
  opt_refuse_a: assert property (
    CMD_WR && CMD_SEL == 4'h9 && CMD_WDATA[0] && CMD_WDATA[2]
    |=> CMD_ERR) else $error("bad option taken");
  opt_outputs_a: assert property (
    CMD_WR && CMD_SEL == 4'h9 && !(CMD_WDATA[0] && CMD_WDATA[2])
    |=> ##1 {POLL_EN, ROUTE_DIS, COORD_EN} == $past(CMD_WDATA[2:0], 2))
    else $error("option outputs wrong");
  bcast_repeat_a: assert property (
    BCAST_FWD == ($past(RX_BCAST) && !ROUTE_DIS))
    else $error("broadcast repeat wrong");
  relay_gate_a: assert property (
    RELAY_OK == ($past(RELAY_REQ) && !ROUTE_DIS))
    else $error("relay gating wrong");
  p2mp_direct_a: assert property (
    P2MP_UNICAST && !P2MP_HOLD ##1 !COORD_EN |-> P2MP_SEND)
    else $error("unicast not sent");
  p2mp_held_a: assert property (
    P2MP_HOLD && !POLL_SEEN && COORD_EN ##1 COORD_EN |-> !P2MP_SEND)
    else $error("held unicast sent");
  poll_spacing_a: assert property (
    POLL_REQ |-> gap_r >= POLL_CYCLES - 1)
    else $error("poll too early");
  poll_bound_a: assert property (
    POLL_EN |-> gap_r <= POLL_CYCLES + 2)
    else $error("poll overdue");
endmodule
bind mss_stats mss_chk #(.POLL_CYCLES(POLL_CYCLES)) mss_chk_inst (
  .MCLK(MCLK), .RST_N(RST_N), .RX_BCAST(RX_BCAST),
  .RELAY_REQ(RELAY_REQ), .P2MP_UNICAST(P2MP_UNICAST),
  .POLL_SEEN(POLL_SEEN), .CMD_WR(CMD_WR), .CMD_RD(CMD_RD),
  .CMD_SEL(CMD_SEL), .CMD_WDATA(CMD_WDATA), .CMD_RVALID(CMD_RVALID),
  .CMD_ERR(CMD_ERR), .COORD_EN(COORD_EN), .ROUTE_DIS(ROUTE_DIS),
  .POLL_EN(POLL_EN), .BCAST_FWD(BCAST_FWD), .RELAY_OK(RELAY_OK),
  .P2MP_HOLD(P2MP_HOLD), .P2MP_SEND(P2MP_SEND), .POLL_REQ(POLL_REQ));
`default_nettype wire

// >>> tb/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               MCLK = 1'b0;
  logic               RST_N = 1'b0;
  logic [5:0]         ev = 6'h00;
  logic [7:0]         RSSI_VAL = 8'h00;
  logic               RSSI_VALID = 1'b0, MAC_PARAM_CHG = 1'b0;
  logic               RX_BCAST = 1'b0, RELAY_REQ = 1'b0;
  logic               P2MP_UNICAST = 1'b0, POLL_SEEN = 1'b0;
  logic               CMD_WR = 1'b0, CMD_RD = 1'b0;
  mss_pkg::mss_sel_t  CMD_SEL = 4'h0;
  mss_pkg::mss_word_t CMD_WDATA = 16'h0000, CMD_RDATA;
  mss_pkg::mss_word_t UNI_HOP_IN = 16'h0000, HOP_B_IN = 16'h0000;
  logic               CMD_RVALID, CMD_ERR, COORD_EN, ROUTE_DIS, POLL_EN;
  logic               BCAST_FWD, RELAY_OK, P2MP_HOLD, P2MP_SEND, POLL_REQ;
  int                 fails = 0;
  int                 compares = 0;
  logic [15:0]        n;
  mss_stats #(.POLL_CYCLES(8)) mss_stats_inst (
    .MCLK(MCLK), .RST_N(RST_N), .TX_BYTE(ev[0]), .RX_FAULT(ev[1]),
    .RX_GOOD(ev[2]), .ACK_TIMEOUT(ev[3]), .RETRY_EXHAUSTED(ev[4]),
    .ACKED_UNICAST(ev[5]), .RSSI_VALID(RSSI_VALID), .RSSI_VAL(RSSI_VAL),
    .MAC_PARAM_CHG(MAC_PARAM_CHG), .UNI_HOP_IN(UNI_HOP_IN),
    .BC_HOP_IN(HOP_B_IN), .RX_BCAST(RX_BCAST), .RELAY_REQ(RELAY_REQ),
    .P2MP_UNICAST(P2MP_UNICAST), .POLL_SEEN(POLL_SEEN), .CMD_WR(CMD_WR),
    .CMD_RD(CMD_RD), .CMD_SEL(CMD_SEL), .CMD_WDATA(CMD_WDATA),
    .CMD_RDATA(CMD_RDATA), .CMD_RVALID(CMD_RVALID), .CMD_ERR(CMD_ERR),
    .COORD_EN(COORD_EN), .ROUTE_DIS(ROUTE_DIS), .POLL_EN(POLL_EN),
    .BCAST_FWD(BCAST_FWD), .RELAY_OK(RELAY_OK), .P2MP_HOLD(P2MP_HOLD),
    .P2MP_SEND(P2MP_SEND), .POLL_REQ(POLL_REQ));
  always #5 MCLK = ~MCLK;
  // every drive lands 1 ns after the edge so sampling never races
  task automatic cyc();
    @(posedge MCLK);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask
  // one write; the extra cycle keeps strobes from toggling twice a step
  task automatic wr(input logic [3:0] s, input logic [15:0] d,
                    input logic e);
    CMD_WR = 1'b1;
    CMD_SEL = s;
    CMD_WDATA = d;
    cyc();
    chk1(CMD_ERR, e);
    CMD_WR = 1'b0;
    cyc();
  endtask
  task automatic rd(input logic [3:0] s, input logic [15:0] d);
    CMD_RD = 1'b1;
    CMD_SEL = s;
    cyc();
    chk1(CMD_RVALID, 1'b1);
    chk(CMD_RDATA, d);
    CMD_RD = 1'b0;
    cyc();
  endtask
  task automatic t_reset();
    logic [15:0] rv [10];
    rv = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
           16'h0000, 16'h00CF, 16'h01BE, 16'h0000};
    for (int s = 0; s < 10; s++) begin
      rd(s[3:0], rv[s]);
    end
    CMD_RD = 1'b1;
    CMD_SEL = 4'hA;
    cyc();
    chk1(CMD_RVALID, 1'b0);
    chk1(CMD_ERR, 1'b1);
    CMD_RD = 1'b0;
    cyc();
  endtask
  task automatic t_wrap();
    wr(4'h0, 16'hFFFF, 1'b0);
    ev[0] = 1'b1;
    cyc();
    ev[0] = 1'b0;
    rd(4'h0, 16'h0000);
    ev[0] = 1'b1;
    repeat (3) cyc();
    ev[0] = 1'b0;
    rd(4'h0, 16'h0003);
  endtask
  // saturating tallies: preload one below the top, then overrun
  task automatic t_sat();
    for (int i = 1; i < 6; i++) begin
      wr(i[3:0], 16'hFFFE, 1'b0);
      ev[i] = 1'b1;
      repeat (3) cyc();
      ev[i] = 1'b0;
      rd(i[3:0], 16'hFFFF);
    end
  endtask
  task automatic t_load();
    CMD_WR = 1'b1;
    CMD_SEL = 4'h3;
    CMD_WDATA = 16'h1234;
    ev[3] = 1'b1;
    cyc();
    CMD_WR = 1'b0;
    ev[3] = 1'b0;
    rd(4'h3, 16'h1234);
    ev[3] = 1'b1;
    cyc();
    ev[3] = 1'b0;
    rd(4'h3, 16'h1235);
  endtask
  task automatic t_ro();
    RSSI_VAL = 8'h60;
    RSSI_VALID = 1'b1;
    UNI_HOP_IN = 16'h0123;
    HOP_B_IN = 16'h0456;
    MAC_PARAM_CHG = 1'b1;
    cyc();
    RSSI_VALID = 1'b0;
    MAC_PARAM_CHG = 1'b0;
    UNI_HOP_IN = 16'h0777;
    for (int s = 6; s < 9; s++) begin
      wr(s[3:0], 16'hFFFF, 1'b1);
    end
    rd(4'h6, 16'h0060);
    rd(4'h7, 16'h0123);
    rd(4'h8, 16'h0456);
  endtask
  task automatic t_opt();
    for (int k = 0; k < 2; k++) begin
      wr(4'h9, k ? 16'h0000 : 16'h0002, 1'b0);
      RX_BCAST = 1'b1;
      RELAY_REQ = 1'b1;
      cyc();
      RX_BCAST = 1'b0;
      RELAY_REQ = 1'b0;
      chk1(BCAST_FWD, k[0]);
      chk1(RELAY_OK, k[0]);
    end
    wr(4'h9, 16'h0005, 1'b1);
    rd(4'h9, 16'h0000);
    wr(4'h9, 16'h0004, 1'b0);
    repeat (2) begin
      n = 16'h0000;
      do begin
        cyc();
        n++;
      end while (POLL_REQ !== 1'b1 && n < 16'h001E);
    end
    chk(n, 16'h0008);
    wr(4'h9, 16'h0001, 1'b0);
    for (int k = 0; k < 2; k++) begin
      P2MP_UNICAST = 1'b1;
      cyc();
      P2MP_UNICAST = 1'b0;
      chk1(P2MP_SEND, 1'b0);
      chk1(P2MP_HOLD, 1'b1);
      POLL_SEEN = !k[0];
      cyc();
      POLL_SEEN = 1'b0;
      chk1(P2MP_SEND, !k[0]);
    end
    // clearing the coordinator bit lets the held unicast go next cycle
    wr(4'h9, 16'h0000, 1'b0);
    chk1(P2MP_SEND, 1'b1);
    chk1(P2MP_HOLD, 1'b0);
    // without the coordinator bit a unicast goes out at once
    P2MP_UNICAST = 1'b1;
    cyc();
    P2MP_UNICAST = 1'b0;
    chk1(P2MP_SEND, 1'b1);
    chk1(P2MP_HOLD, 1'b0);
  endtask
  task automatic final_report();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge MCLK);
    #1;
    RST_N = 1'b1;
    t_reset();
    t_wrap();
    t_sat();
    t_load();
    t_ro();
    t_opt();
    final_report();
  end
  // the tests need well under 1000 cycles
  initial begin
    #30000;
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
